// ### pm_pkg.sv
// Behaviour
// - input byte: overvoltage 7, undervoltage 4, low-input off 3
// - thermal byte: fault 7, warning 6, 5:0 reserved
// - comms byte: bad command 7, bad data 6, PEC 5
// - revision byte reports 1.2 for both parts
// - revision codes 000/001/010 and 0000/0001/0010 mean 1.0/1.1/1.2
// - type word: high byte reserved, name 7:2, protect 1
// - protect bit clear means writes are allowed
// - protect bit set refuses writes to protected fields
// - summary bits 13, 2, 1 follow the three bytes
package pm_pkg;
   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_IN = 8'h7C;
   localparam logic [7:0] CMD_TH = 8'h7D;
   localparam logic [7:0] CMD_CM = 8'h7E;
   localparam logic [7:0] CMD_VIN = 8'h88;
   localparam logic [7:0] CMD_VOUT = 8'h8B;
   localparam logic [7:0] CMD_IOUT = 8'h8C;
   localparam logic [7:0] CMD_TEMP = 8'h8D;
   localparam logic [7:0] CMD_REV = 8'h98;
   localparam logic [7:0] CMD_MTYPE = 8'hD0;
   // ---------------------------------------------------------------
   // field layouts
   // ---------------------------------------------------------------
   localparam int IN_OV_BIT = 7;
   localparam int IN_UV_BIT = 4;
   localparam int IN_OFF_BIT = 3;
   localparam int TH_FAULT_BIT = 7;
   localparam int TH_WARN_BIT = 6;
   localparam int CM_CMD_BIT = 7;
   localparam int CM_DATA_BIT = 6;
   localparam int CM_PEC_BIT = 5;
   localparam logic [7:0] IN_MASK = 8'h98;
   localparam logic [7:0] TH_MASK = 8'hC0;
   localparam logic [7:0] CM_MASK = 8'hE0;
   localparam logic [2:0] PART1_V12 = 3'h2;
   localparam logic [3:0] PART2_V12 = 4'h2;
   localparam logic [7:0] REV_VALUE = {PART1_V12, 1'b0, PART2_V12};
   localparam int MT_RES_BIT = 0;
   localparam int MT_WP_BIT = 1;
   localparam int MT_NAME_LSB = 2;
   localparam int MT_NAME_W = 6;
   localparam int SUM_IN_BIT = 13;
   localparam int SUM_TH_BIT = 2;
   localparam int SUM_CM_BIT = 1;
   // ---------------------------------------------------------------
   // command kinds {known, writable, word}
   // ---------------------------------------------------------------
   localparam int K_KNOWN = 2;
   localparam int K_WR = 1;
   localparam int K_WORD = 0;
   localparam logic [2:0] KIND_STATUS = 3'h6;
   localparam logic [2:0] KIND_MTYPE = 3'h7;
   localparam logic [2:0] KIND_TELEM = 3'h5;
   localparam logic [2:0] KIND_REV = 3'h4;
   localparam logic [2:0] KIND_NONE = 3'h0;
   // decode of a command byte into its kind
   function automatic logic [2:0] cmd_kind(input logic [7:0] c);
      if (c == CMD_IN || c == CMD_TH || c == CMD_CM) begin
         return KIND_STATUS;
      end else if (c == CMD_MTYPE) begin
         return KIND_MTYPE;
      end else if (c == CMD_VIN || c == CMD_VOUT || c == CMD_IOUT || c == CMD_TEMP) begin
         return KIND_TELEM;
      end else if (c == CMD_REV) begin
         return KIND_REV;
      end else begin
         return KIND_NONE;
      end
   endfunction : cmd_kind
   // ---------------------------------------------------------------
   // link framing
   // ---------------------------------------------------------------
   localparam logic [7:0] PEC_POLY = 8'h07;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] WN_MAX = 3'h7;
   localparam int SEL_IN = 0;
   localparam int SEL_TH = 1;
   localparam int SEL_CM = 2;
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_rx = 3'h1,
      st_rack = 3'h3,
      st_tx = 3'h2,
      st_tack = 3'h6
   } link_st_t;
endpackage : pm_pkg

// ### status_byte_if.sv
`timescale 1ns/1ns
`default_nettype none
// one sticky status byte: set and clear masks in, flag value out
interface status_byte_if;
   logic [7:0] set;
   logic [7:0] clr;
   logic [7:0] val;
   modport owner (input set, input clr, output val);
   modport user (output set, output clr, input val);
endinterface : status_byte_if
`default_nettype wire

// ### pin_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync2 #(
   parameter int W = 2
) (
   input wire logic i_clk,          // controller clock
   input wire logic i_rst_b,        // async reset, active low
   input wire logic [W-1:0] i_d,    // pins from outside the clock domain
   output logic [W-1:0] o_q         // synchronised copy
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t r, n;
   // first stage feeds only the second stage
   always_comb begin
      n = r;
      n.s1 = i_d;
      n.s2 = r.s1;
   end
   // bus idles high, so reset to ones avoids a false edge
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r <= '1;
      end else begin
         r <= n;
      end
   end
   assign o_q = r.s2;
endmodule : pin_sync2
`default_nettype wire

// ### w1c_status_byte.sv
`timescale 1ns/1ns
`default_nettype none
module w1c_status_byte #(
   parameter logic [7:0] SUPPORTED = 8'hFF
) (
   input wire logic i_clk,          // controller clock
   input wire logic i_rst_b,        // async reset, active low
   status_byte_if.owner bus         // set, clear and value
);
   typedef struct packed {
      logic [7:0] val;
   } flag_t;
   flag_t r, n;
   // set beats clear in the same cycle so no event is lost
   always_comb begin
      n = r;
      n.val = ((r.val & ~bus.clr) | bus.set) & SUPPORTED;
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign bus.val = r.val;
endmodule : w1c_status_byte
`default_nettype wire

// ### pmbus_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
module pmbus_status_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h40,   // bus address, arbitrary default
   parameter logic [5:0] MODULE_NAME = 6'h00 // name code, arbitrary value
) (
   input wire logic i_clk,                       // 10 MHz controller clock
   input wire logic i_rst_b,                     // async reset, active low
   input wire logic i_scl,                       // bus clock pin
   input wire logic i_sda,                       // bus data pin level
   output logic o_sda_out,                       // data pin drive value
   output logic o_sda_oe,                        // data pin pulled low
   input wire logic i_input_overvoltage_fault,   // input overvoltage seen
   input wire logic i_input_undervoltage_fault,  // input undervoltage seen
   input wire logic i_input_low_unit_off,        // unit off on low input
   input wire logic i_overtemperature_fault,     // thermal fault seen
   input wire logic i_overtemperature_warning,   // thermal warning seen
   input wire logic [15:0] i_input_voltage,      // input voltage telemetry
   input wire logic [15:0] i_output_voltage,     // output voltage telemetry
   input wire logic [15:0] i_output_current,     // output current telemetry
   input wire logic [15:0] i_temperature,        // temperature telemetry
   output logic o_write_protect,                 // protection active
   output logic [15:0] o_status_summary          // summary status bits
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      pm_pkg::link_st_t st;
      logic scl_d, sda_d, first, have_cmd, rw, oe, wr_prot;
      logic ev_cmd, ev_data, ev_pec;
      logic [7:0] sh, cmd, crc, clr_byte;
      logic [3:0] bits;
      logic [2:0] wn, clr_sel;
      logic [15:0] wbuf, txw, summ;
      logic [1:0] txn;
      logic [5:0] name;
   } state_t;
   state_t r, n;
   logic [1:0] pins_s;
   logic scl_s, sda_s, rise, fall, start, stop, load_tx, mt_commit, any_in, any_th, any_cm;
   logic [2:0] kind, nk;
   logic [1:0] tx_len;
   logic [7:0] txb;
   logic [15:0] rd;
   status_byte_if in_if ();
   status_byte_if th_if ();
   status_byte_if cm_if ();

   // ---------------------------------------------------------------
   // pins and flag bytes
   // ---------------------------------------------------------------
   pin_sync2 #(.W(2)) u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_d({i_scl, i_sda}),
      .o_q(pins_s)
   );
   w1c_status_byte #(.SUPPORTED(pm_pkg::IN_MASK)) u_in (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .bus(in_if.owner));
   w1c_status_byte #(.SUPPORTED(pm_pkg::TH_MASK)) u_th (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .bus(th_if.owner));
   w1c_status_byte #(.SUPPORTED(pm_pkg::CM_MASK)) u_cm (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .bus(cm_if.owner));

   // condition levels set flags every cycle they are present
   assign in_if.set = ({7'h00, i_input_overvoltage_fault} << pm_pkg::IN_OV_BIT)
      | ({7'h00, i_input_undervoltage_fault} << pm_pkg::IN_UV_BIT)
      | ({7'h00, i_input_low_unit_off} << pm_pkg::IN_OFF_BIT);
   assign th_if.set = ({7'h00, i_overtemperature_fault} << pm_pkg::TH_FAULT_BIT)
      | ({7'h00, i_overtemperature_warning} << pm_pkg::TH_WARN_BIT);
   assign cm_if.set = ({7'h00, r.ev_cmd} << pm_pkg::CM_CMD_BIT)
      | ({7'h00, r.ev_data} << pm_pkg::CM_DATA_BIT)
      | ({7'h00, r.ev_pec} << pm_pkg::CM_PEC_BIT);
   assign in_if.clr = r.clr_sel[pm_pkg::SEL_IN] ? r.clr_byte : 8'h00;
   assign th_if.clr = r.clr_sel[pm_pkg::SEL_TH] ? r.clr_byte : 8'h00;
   assign cm_if.clr = r.clr_sel[pm_pkg::SEL_CM] ? r.clr_byte : 8'h00;

   // bus events, from synchronised pins only
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];
   assign rise = !r.scl_d && scl_s;
   assign fall = r.scl_d && !scl_s;
   assign start = r.sda_d && !sda_s && scl_s && r.scl_d;
   assign stop = !r.sda_d && sda_s && scl_s && r.scl_d;
   assign load_tx = fall && (r.st == pm_pkg::st_tack || (r.st == pm_pkg::st_rack && r.rw));
   assign any_in = |in_if.val;
   assign any_th = |th_if.val;
   assign any_cm = |cm_if.val;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? pm_pkg::PEC_POLY : 8'h00);
   endfunction : crc_step

   // read word for the latched command; telemetry is captured once at the
   // read address so both bytes of a word belong to the same sample
   always_comb begin
      if (r.cmd == pm_pkg::CMD_IN) begin
         rd = {8'h00, in_if.val};
      end else if (r.cmd == pm_pkg::CMD_TH) begin
         rd = {8'h00, th_if.val};
      end else if (r.cmd == pm_pkg::CMD_CM) begin
         rd = {8'h00, cm_if.val};
      end else if (r.cmd == pm_pkg::CMD_VIN) begin
         rd = i_input_voltage;
      end else if (r.cmd == pm_pkg::CMD_VOUT) begin
         rd = i_output_voltage;
      end else if (r.cmd == pm_pkg::CMD_IOUT) begin
         rd = i_output_current;
      end else if (r.cmd == pm_pkg::CMD_TEMP) begin
         rd = i_temperature;
      end else if (r.cmd == pm_pkg::CMD_REV) begin
         rd = {8'h00, pm_pkg::REV_VALUE};
      end else if (r.cmd == pm_pkg::CMD_MTYPE) begin
         rd = {8'h00, r.name, r.wr_prot, 1'b0};
      end else begin
         rd = {pm_pkg::IDLE_BYTE, pm_pkg::IDLE_BYTE};
      end
   end

   // ---------------------------------------------------------------
   // link engine and register writes
   // ---------------------------------------------------------------
   always_comb begin
      n = r;
      mt_commit = 1'b0;
      kind = pm_pkg::cmd_kind(r.cmd);
      nk = pm_pkg::cmd_kind(r.sh);
      tx_len = kind[pm_pkg::K_WORD] ? 2'h2 : 2'h1;
      if (r.txn < tx_len) begin
         txb = (r.txn == 2'h0) ? r.txw[7:0] : r.txw[15:8];
      end else if (r.txn == tx_len) begin
         txb = r.crc; // trailing check byte
      end else begin
         txb = pm_pkg::IDLE_BYTE;
      end
      n.scl_d = scl_s;
      n.sda_d = sda_s;
      n.ev_cmd = 1'b0;
      n.ev_data = 1'b0;
      n.ev_pec = 1'b0;
      n.clr_sel = 3'h0;
      n.summ = 16'h0000;
      n.summ[pm_pkg::SUM_IN_BIT] = any_in;
      n.summ[pm_pkg::SUM_TH_BIT] = any_th;
      n.summ[pm_pkg::SUM_CM_BIT] = any_cm;
      if (start) begin
         n.st = pm_pkg::st_rx;
         n.bits = 4'h0;
         n.first = 1'b1;
         n.oe = 1'b0;
         // a repeated start keeps the command and the running check
         if (r.st == pm_pkg::st_idle) begin
            n.crc = 8'h00;
            n.have_cmd = 1'b0;
            n.wn = 3'h0;
            n.rw = 1'b0;
         end
      end else if (stop) begin
         n.st = pm_pkg::st_idle;
         n.oe = 1'b0;
         // writes act only at stop, after the check byte is known
         if (!r.rw && r.have_cmd && r.wn != 3'h0 && kind[pm_pkg::K_KNOWN]) begin
            if (!kind[pm_pkg::K_WR]) begin
               n.ev_data = 1'b1;
            end else if (r.wn == {1'b0, tx_len}
                  || (r.wn == {1'b0, tx_len} + 3'h1 && r.crc == 8'h00)) begin
               if (r.cmd == pm_pkg::CMD_MTYPE) begin
                  mt_commit = 1'b1;
                  n.wr_prot = r.wbuf[pm_pkg::MT_WP_BIT];
                  if (!r.wr_prot) begin
                     n.name = r.wbuf[pm_pkg::MT_NAME_LSB +: pm_pkg::MT_NAME_W];
                  end
               end else begin
                  n.clr_byte = r.wbuf[7:0];
                  n.clr_sel = {r.cmd == pm_pkg::CMD_CM, r.cmd == pm_pkg::CMD_TH,
                     r.cmd == pm_pkg::CMD_IN};
               end
            end else if (r.wn == {1'b0, tx_len} + 3'h1) begin
               n.ev_pec = 1'b1;
            end else begin
               n.ev_data = 1'b1;
            end
         end
      end else begin
         case (r.st)
            pm_pkg::st_rx: begin
               if (rise && r.bits != pm_pkg::BYTE_BITS) begin
                  n.sh = {r.sh[6:0], sda_s};
                  n.bits = r.bits + 4'h1;
               end else if (fall && r.bits != 4'h0 && r.bits != pm_pkg::BYTE_BITS) begin
                  // check advances on the fall: the rise ahead of a repeated start never counts
                  n.crc = crc_step(r.crc, r.sh[0]);
               end else if (fall && r.bits == pm_pkg::BYTE_BITS) begin
                  n.crc = crc_step(r.crc, r.sh[0]);
                  n.bits = 4'h0;
                  n.st = pm_pkg::st_rack;
                  n.oe = 1'b1;
                  if (r.first) begin
                     n.first = 1'b0;
                     n.rw = r.sh[0];
                     n.txw = rd;
                     n.txn = 2'h0;
                     if (r.sh[7:1] != DEV_ADDR) begin
                        n.st = pm_pkg::st_idle;
                        n.oe = 1'b0;
                     end
                  end else if (!r.have_cmd) begin
                     n.cmd = r.sh;
                     n.have_cmd = 1'b1;
                     n.ev_cmd = !nk[pm_pkg::K_KNOWN];
                  end else begin
                     if (r.wn == 3'h0) begin
                        n.wbuf[7:0] = r.sh;
                     end else if (r.wn == 3'h1) begin
                        n.wbuf[15:8] = r.sh;
                     end
                     if (r.wn != pm_pkg::WN_MAX) begin
                        n.wn = r.wn + 3'h1;
                     end
                  end
               end
            end
            pm_pkg::st_rack: begin
               if (fall && !r.rw) begin
                  n.oe = 1'b0;
                  n.st = pm_pkg::st_rx;
               end
            end
            pm_pkg::st_tx: begin
               if (rise) begin
                  n.crc = crc_step(r.crc, sda_s);
                  n.bits = r.bits + 4'h1;
               end else if (fall && r.bits == pm_pkg::BYTE_BITS) begin
                  n.oe = 1'b0;
                  n.st = pm_pkg::st_tack;
               end else if (fall) begin
                  n.sh = {r.sh[6:0], 1'b0};
                  n.oe = !r.sh[6];
               end
            end
            pm_pkg::st_tack: begin
               if (rise && sda_s) begin
                  n.st = pm_pkg::st_idle; // master ends the read
               end
            end
            default: begin
               n.st = pm_pkg::st_idle;
            end
         endcase
         if (load_tx) begin
            n.sh = txb;
            n.txn = (r.txn == 2'h3) ? r.txn : r.txn + 2'h1;
            n.oe = !txb[7];
            n.bits = 4'h0;
            n.st = pm_pkg::st_tx;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r <= '0;
         r.scl_d <= 1'b1;
         r.sda_d <= 1'b1;
         r.name <= MODULE_NAME;
      end else begin
         r <= n;
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe = r.oe;
   assign o_write_protect = r.wr_prot;
   assign o_status_summary = r.summ;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   property p_in_ov;
      i_input_overvoltage_fault ##1 i_input_undervoltage_fault |=>
         in_if.val[pm_pkg::IN_OV_BIT] && in_if.val[pm_pkg::IN_UV_BIT];
   endproperty
   a_in_ov: assert property (p_in_ov) else $error("input flags not set");
   property p_th;
      i_overtemperature_warning |=> th_if.val[pm_pkg::TH_WARN_BIT]
         && (th_if.val & ~pm_pkg::TH_MASK) == 8'h00;
   endproperty
   a_th: assert property (p_th) else $error("thermal byte wrong");
   property p_pec;
      r.ev_pec |=> cm_if.val[pm_pkg::CM_PEC_BIT] && !$past(stop);
   endproperty
   a_pec: assert property (p_pec) else $error("check error not flagged");
   property p_rev;
      load_tx && r.txn == 2'h0 && r.cmd == pm_pkg::CMD_REV |=> r.sh == pm_pkg::REV_VALUE;
   endproperty
   a_rev: assert property (p_rev) else $error("revision byte wrong");
   property p_rev_code;
      load_tx && r.cmd == pm_pkg::CMD_REV && r.txn == 2'h0 |=>
         r.sh[7:5] == pm_pkg::PART1_V12 && r.sh[3:0] == pm_pkg::PART2_V12 ##1 o_sda_oe [*1];
   endproperty
   a_rev_code: assert property (p_rev_code) else $error("revision code wrong");
   property p_mtype;
      load_tx && r.cmd == pm_pkg::CMD_MTYPE |=> (r.txn == 2'h2 && r.sh == 8'h00)
         || (r.sh[pm_pkg::MT_RES_BIT] == 1'b0 && r.sh[pm_pkg::MT_WP_BIT] == r.wr_prot);
   endproperty
   a_mtype: assert property (p_mtype) else $error("type word wrong");
   property p_wp_off;
      mt_commit && !r.wr_prot |=> r.name == $past(r.wbuf[7:2]);
   endproperty
   a_wp_off: assert property (p_wp_off) else $error("name not written");
   property p_wp_on;
      mt_commit && r.wr_prot |=> $stable(r.name) [*2];
   endproperty
   a_wp_on: assert property (p_wp_on) else $error("protected name changed");
   property p_sum;
      any_th ##1 any_th |-> o_status_summary[pm_pkg::SUM_TH_BIT]
         && o_status_summary[pm_pkg::SUM_IN_BIT] == $past(any_in);
   endproperty
   a_sum: assert property (p_sum) else $error("summary bit wrong");
   property p_sticky;
      in_if.val[pm_pkg::IN_OV_BIT] && !in_if.clr[pm_pkg::IN_OV_BIT] |=>
         in_if.val[pm_pkg::IN_OV_BIT] && (in_if.val & ~pm_pkg::IN_MASK) == 8'h00;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost or bad bit");

   c_word_read: cover property (load_tx && r.cmd == pm_pkg::CMD_VIN ##[1:300] load_tx);
   c_pec_fail: cover property (r.ev_pec);
   c_wp_refuse: cover property (mt_commit && r.wr_prot);
   c_clear: cover property (|in_if.clr);
endmodule : pmbus_status_regs
`default_nettype wire

// ### pmbus_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// bus host: makes the clock and pulls the data line low, releases it otherwise
module pmbus_host_model (
   input wire logic i_clk,  // controller clock
   input wire logic i_sda,  // resolved data line
   output logic o_scl,      // bus clock
   output logic o_sda_low   // high = host pulls data low
);
   // idle bus: both lines high
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // 8 cycles a phase, four times the two synchroniser stages
   task automatic wait_phase();
      repeat (8) @(negedge i_clk);
   endtask : wait_phase
   // start or repeated start; data is released while the clock is low, then pulled low with the clock high
   task automatic start();
      o_sda_low = 1'b0;
      wait_phase();
      o_scl = 1'b1;
      wait_phase();
      o_sda_low = 1'b1;
      wait_phase();
      o_scl = 1'b0;
      wait_phase();
   endtask : start
   task automatic stop();
      o_sda_low = 1'b1;
      wait_phase();
      o_scl = 1'b1;
      wait_phase();
      o_sda_low = 1'b0;
      wait_phase();
   endtask : stop
   // one clock pulse; the line is sampled at the end of the high phase
   task automatic send_bit(input logic b, output logic r);
      o_sda_low = !b;
      wait_phase();
      o_scl = 1'b1;
      wait_phase();
      r = i_sda;
      o_scl = 1'b0;
      wait_phase();
   endtask : send_bit
   task automatic tx(input logic [7:0] b, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i], r);
      end
      send_bit(1'b1, ack_n);
   endtask : tx
   task automatic rx(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         send_bit(1'b1, b[i]);
      end
      send_bit(last, r);
   endtask : rx
endmodule : pmbus_host_model
`default_nettype wire

// ### pmbus_status_and_identity_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pmbus_status_and_identity_regs_tb_top;
   logic i_clk = 1'b0;
   logic i_rst_b, scl, host_low, sda_oe, sda_out, wp;
   wire sda;
   logic [4:0] flt;
   logic [15:0] tel [4];
   logic [15:0] summ, v;
   logic [31:0] seed = 32'h48C9;
   logic [7:0] cmds [4] = '{8'h88, 8'h8B, 8'h8C, 8'h8D};
   logic [15:0] wt [4] = '{16'hFF57, 16'h00AA, 16'h00A8, 16'h00A8};
   int num_errors = 0, checked = 0, cyc = 0, nm = 0, wpm = 0;
   int fl [3] = '{0, 0, 0};
   // open-drain data line with pull-up
   assign sda = !(host_low | (sda_oe & !sda_out));
   initial begin
      forever #50 i_clk = !i_clk;
   end
   pmbus_status_regs pmbus_status_regs_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(scl),
      .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_input_overvoltage_fault(flt[0]),
      .i_input_undervoltage_fault(flt[1]), .i_input_low_unit_off(flt[2]),
      .i_overtemperature_fault(flt[3]), .i_overtemperature_warning(flt[4]),
      .i_input_voltage(tel[0]), .i_output_voltage(tel[1]), .i_output_current(tel[2]),
      .i_temperature(tel[3]), .o_write_protect(wp), .o_status_summary(summ));
   pmbus_host_model pmbus_host_model_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(host_low));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // bitwise packet check over address, command and data, msb first
   function automatic logic [7:0] crc(input logic [31:0] m);
      logic [7:0] c = 8'h00;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : crc
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] c, input logic [23:0] d, input int n);
      logic a;
      pmbus_host_model_i.start();
      pmbus_host_model_i.tx(8'h80, a);
      chk("address ack", 16'h0000, {15'h0000, a});
      pmbus_host_model_i.tx(c, a);
      for (int i = 0; i < n; i++) pmbus_host_model_i.tx(d[8*i +: 8], a);
      pmbus_host_model_i.stop();
      repeat (4) @(negedge i_clk);
   endtask : wr
   // words arrive low byte first; the last byte is refused to end the read
   task automatic rd(input logic [7:0] c, input int n, output logic [15:0] r);
      logic a;
      logic [7:0] b;
      r = 16'h0000;
      pmbus_host_model_i.start();
      pmbus_host_model_i.tx(8'h80, a);
      pmbus_host_model_i.tx(c, a);
      pmbus_host_model_i.start();
      pmbus_host_model_i.tx(8'h81, a);
      for (int i = 0; i < n; i++) begin
         pmbus_host_model_i.rx(i == n - 1, b);
         r[8*i +: 8] = b;
      end
      pmbus_host_model_i.stop();
   endtask : rd
   // reads all three flag bytes and the summary against the model
   task automatic flags_chk();
      for (int k = 0; k < 3; k++) begin
         rd(8'h7C + k[7:0], 1, v);
         chk("flag byte", fl[k][15:0], v);
      end
      chk("summary", {2'b00, fl[0] != 0, 10'h000, fl[1] != 0, fl[2] != 0, 1'b0}, summ);
   endtask : flags_chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // cuts a hang short; a full run takes about 40000 cycles
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      i_rst_b = 1'b0;
      flt = 5'h00;
      tel = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      repeat (6) @(negedge i_clk);
      i_rst_b = 1'b1;
      repeat (4) @(negedge i_clk);
      rd(8'h98, 1, v);
      chk("revision", 16'h0042, v);
      // the byte after the data is the check over every byte, repeated address included
      rd(8'h98, 2, v);
      chk("revision check byte", {crc(32'h80988142), 8'h42}, v);
      $display("test identity done");
      // short random fault pulses must leave sticky flags behind
      for (int k = 0; k < 5; k++) begin
         flt[k] = 1'b1;
         repeat (xs() % 5 + 1) @(negedge i_clk);
         flt[k] = 1'b0;
      end
      fl[0] = 'h98;
      fl[1] = 'hC0;
      flags_chk();
      wr(8'h7C, 24'h000010, 1);
      fl[0] = 'h88;
      flags_chk();
      wr(8'h7C, 24'h0000FF, 1);
      wr(8'h7D, 24'h0000FF, 1);
      fl = '{0, 0, 0};
      flags_chk();
      $display("test fault flags done");
      for (int k = 0; k < 4; k++) tel[k] = xs() % 65536;
      wr(8'h88, 24'h001234, 2);
      fl[2] = 'h40;
      flags_chk();
      wr(8'h7C, {8'h00, crc(24'h807C00) ^ 8'h01, 8'h00}, 2);
      fl[2] = 'h60;
      flags_chk();
      wr(8'h55, 24'h000000, 1);
      fl[2] = 'hE0;
      flags_chk();
      wr(8'h7E, 24'h0000FF, 1);
      fl[2] = 0;
      flags_chk();
      for (int k = 0; k < 4; k++) begin
         rd(cmds[k], 2, v);
         chk("telemetry", tel[k], v);
      end
      $display("test comms and telemetry done");
      rd(8'hD0, 2, v);
      chk("type word", 16'h0000, v);
      // protect bit as held before each write decides whether the name changes
      for (int k = 0; k < 4; k++) begin
         wr(8'hD0, {8'h00, wt[k]}, 2);
         if (wpm == 0) nm = wt[k][7:2];
         wpm = wt[k][1];
         rd(8'hD0, 2, v);
         chk("type word", {8'h00, nm[5:0], wpm[0], 1'b0}, v);
         chk("protect out", {15'h0000, wpm[0]}, {15'h0000, wp});
      end
      $display("test write protect done");
      close_out();
   end
endmodule : pmbus_status_and_identity_regs_tb_top
`default_nettype wire
